/* File: shared/eeprom_pkg.sv */
package eeprom_pkg;
    // Device type nibble every target answers to
    localparam logic [3:0] DEV_TYPE = 4'ha;
    localparam int ADDR_W = 17;
    localparam int PAGE_BYTES = 256;

    // Timing, 50 MHz system clock
    localparam int CLK_NS = 20;
    localparam int CLK_KHZ = 50_000;
    localparam int WRITE_TIME_MS = 5;
    // Longest time, rounded down
    localparam int WRITE_CYCLES = WRITE_TIME_MS * CLK_KHZ;
    localparam int SCL_LOW_NS = 1300;
    // Half the low time per quarter step, rounded up
    localparam int QUARTER_CYCLES = (SCL_LOW_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);

    // Controller register map
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] TXD_OFS = 8'h04;
    localparam logic [7:0] RXD_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0c;
    localparam int CMD_LSB = 0;
    localparam int ACK_OUT_BIT = 3;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ACK_BIT = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Command codes in the control register
    localparam logic [2:0] CMD_START = 3'h1;
    localparam logic [2:0] CMD_STOP = 3'h2;
    localparam logic [2:0] CMD_WRITE = 3'h3;
    localparam logic [2:0] CMD_READ = 3'h4;
endpackage

/* File: shared/twi_if.sv */
`timescale 1ns/1ps
interface twi_if;
    logic scl_ctl_o;
    logic scl_ctl_oe;
    logic sda_ctl_o;
    logic sda_ctl_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic scl;
    logic sda;

    // Open-drain wires with pull-up
    assign scl = !(scl_ctl_oe && !scl_ctl_o);
    assign sda = !(sda_ctl_oe && !sda_ctl_o) && !(sda_dev_oe && !sda_dev_o);

    modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
    modport controller (input scl, input sda, output scl_ctl_o, output scl_ctl_oe,
        output sda_ctl_o, output sda_ctl_oe);
endinterface

/* File: tb/eeprom_link_monitor.sv */
`timescale 1ns/1ps
module eeprom_link_monitor #(
    parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic scl,
    input wire logic sda_dev_oe,
    input wire logic BUSY,
    input wire logic STANDBY,
    input wire logic MEM_WE
);
    // Length of the running write cycle; a counter, since it is far beyond a repetition
    int busy_cnt_r;
    int busy_cnt_nxt;

    always_comb
    begin
        busy_cnt_nxt = BUSY ? busy_cnt_r + 1 : 0;
    end

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            busy_cnt_r <= 0;
        else
            busy_cnt_r <= busy_cnt_nxt;
    end

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    a_quiet_while_busy: assert property (BUSY |-> !sda_dev_oe)
        else $error("target drove the data line during its write cycle");
    a_busy_bounded: assert property (busy_cnt_r <= WRITE_CYCLES)
        else $error("write cycle ran longer than allowed");
    a_busy_full_length: assert property ($fell(BUSY) |-> busy_cnt_r >= WRITE_CYCLES - 3)
        else $error("write cycle ended early");
    a_standby_after_write: assert property ($fell(BUSY) |-> ##[0:2] STANDBY)
        else $error("no standby after write cycle");
    a_busy_not_standby: assert property (BUSY |-> !STANDBY)
        else $error("standby flagged during write cycle");
    a_store_in_busy: assert property (MEM_WE |=> BUSY)
        else $error("array store outside a write cycle");
    a_drive_scl_low: assert property ($rose(sda_dev_oe) |-> !scl)
        else $error("target pulled data while clock high");
    a_release_scl_low: assert property ($fell(sda_dev_oe) |-> !scl)
        else $error("target released data while clock high");
    a_standby_silent: assert property (STANDBY |-> !sda_dev_oe)
        else $error("target drove data while in standby");

    c_write_cycle: cover property ($rose(BUSY));
    c_ack_seen: cover property ($rose(sda_dev_oe));
    c_page_store: cover property (MEM_WE ##1 MEM_WE);
endmodule

/* File: tb/i2c_eeprom_write_addressing_tb.sv */
`timescale 1ns/1ps
module i2c_eeprom_write_addressing_tb;
    // Long enough that the first poll is refused, short enough for a quick run
    localparam int WCYC = 3000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [7:0] rdata;
    logic [1:0] straps = 2'b10;
    logic wp = 1'b0;
    logic [7:0] mem [0:131071];
    logic [16:0] raddr;
    logic [16:0] waddr;
    logic [7:0] wdat;
    logic we;
    logic busy;
    logic standby;
    int err_count = 0;
    int tests_run = 0;

    twi_if link ();

    always #10 clk = ~clk;

    always @(posedge clk)
        if (we)
            mem[waddr] <= wdat;

    twi_controller u_twi_controller (.CLK_SYS(clk), .RST(rst), .LINK(link), .ADDR(addr),
        .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata));
    eeprom_target #(.WRITE_CYCLES(WCYC)) u_eeprom_target (.CLK_SYS(clk), .RST(rst),
        .LINK(link), .DEVICE_SELECT_STRAP_HIGH(straps[1]), .DEVICE_SELECT_STRAP_LOW(straps[0]),
        .WRITE_PROTECT(wp), .MEM_RDATA(mem[raddr]), .MEM_RADDR(raddr), .MEM_WADDR(waddr),
        .MEM_WDATA(wdat), .MEM_WE(we), .BUSY(busy), .STANDBY(standby));
    eeprom_link_monitor #(.WRITE_CYCLES(WCYC)) u_eeprom_link_monitor (.CLK_SYS(clk),
        .RST(rst), .scl(link.scl), .sda_dev_oe(link.sda_dev_oe), .BUSY(busy),
        .STANDBY(standby), .MEM_WE(we));

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask

    task automatic cmd(input logic [3:0] c, input logic [7:0] d, output logic ack);
        logic [7:0] s;
        int n;
        wr(eeprom_pkg::TXD_OFS, d);
        wr(eeprom_pkg::CTRL_OFS, {4'h0, c});
        s = 8'h01;
        for (n = 0; n < 2000 && s[eeprom_pkg::STAT_BUSY_BIT] !== 1'b0; n++)
            rd(eeprom_pkg::STAT_OFS, s);
        if (n == 2000)
        begin
            err_count++;
            $display("BAD t=%0t controller never finished", $time);
            summarize();
        end
        ack = s[eeprom_pkg::STAT_ACK_BIT];
    endtask

    task automatic ctl(input logic [2:0] c);
        logic a;
        cmd({1'b0, c}, 8'h00, a);
    endtask

    // Sends one byte; exp is whether the target should acknowledge it
    task automatic send(input logic [7:0] b, input logic exp);
        logic a;
        cmd({1'b0, eeprom_pkg::CMD_WRITE}, b, a);
        check(a, exp);
    endtask

    function automatic logic [7:0] devw(input logic [1:0] sel, input logic p, input logic r);
        return {eeprom_pkg::DEV_TYPE, sel, p, r};
    endfunction

    initial
    begin
        logic a;
        logic [7:0] v;
        int i;
        mem[17'h11201] = 8'h5c;
        mem[17'h11202] = 8'h7e;
        mem[17'h00007] = 8'h3c;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        check(standby, 1'b1);
        rd(eeprom_pkg::STAT_OFS, v);
        check(v, 8'h00);
        rd(8'h10, v);
        check(v, 8'h00);
        $display("test reset done");

        // Straps are 10: only that select answers, a wrong type nibble never does
        for (i = 0; i < 5; i++)
        begin
            ctl(eeprom_pkg::CMD_START);
            send(i < 4 ? devw(i[1:0], 1'b0, 1'b0) : 8'hb8, i == 2);
            if (i != 2)
                check(standby, 1'b1);
            ctl(eeprom_pkg::CMD_STOP);
        end
        $display("test decode done");

        // Page write straddling the page end, top address bit set
        ctl(eeprom_pkg::CMD_START);
        send(devw(straps, 1'b1, 1'b0), 1'b1);
        send(8'h12, 1'b1);
        send(8'hfe, 1'b1);
        for (i = 0; i < 3; i++)
            send(8'ha1 + i[7:0], 1'b1);
        ctl(eeprom_pkg::CMD_STOP);
        // Stop is seen a few clocks after SDA rises
        repeat (4) @(posedge clk);
        check(busy, 1'b1);
        check(raddr, 17'h11201);
        ctl(eeprom_pkg::CMD_START);
        send(devw(straps, 1'b0, 1'b0), 1'b0);
        ctl(eeprom_pkg::CMD_STOP);
        a = 1'b0;
        for (i = 0; i < 4 && a !== 1'b1; i++)
        begin
            ctl(eeprom_pkg::CMD_START);
            cmd({1'b0, eeprom_pkg::CMD_WRITE}, devw(straps, 1'b0, 1'b0), a);
            ctl(eeprom_pkg::CMD_STOP);
        end
        check(a, 1'b1);
        repeat (4) @(posedge clk);
        check(standby, 1'b1);
        check(mem[17'h112fe], 8'ha1);
        check(mem[17'h112ff], 8'ha2);
        check(mem[17'h11200], 8'ha3);
        $display("test page write done");

        // Random read through a dummy write, then protocol recovery
        ctl(eeprom_pkg::CMD_START);
        send(devw(straps, 1'b1, 1'b0), 1'b1);
        send(8'h12, 1'b1);
        send(8'h01, 1'b1);
        ctl(eeprom_pkg::CMD_START);
        send(devw(straps, 1'b1, 1'b1), 1'b1);
        // Bit 3 set: controller acks, so a second byte follows
        cmd({1'b1, eeprom_pkg::CMD_READ}, 8'h00, a);
        check(a, 1'b1);
        rd(eeprom_pkg::RXD_OFS, v);
        check(v, 8'h5c);
        check(raddr, 17'h11202);
        ctl(eeprom_pkg::CMD_READ);
        rd(eeprom_pkg::RXD_OFS, v);
        check(v, 8'h7e);
        check(raddr, 17'h11203);
        ctl(eeprom_pkg::CMD_START);
        ctl(eeprom_pkg::CMD_READ);
        ctl(eeprom_pkg::CMD_START);
        ctl(eeprom_pkg::CMD_STOP);
        $display("test read and recovery done");

        // Protected write: bytes acknowledged, nothing stored, no write cycle
        wp <= 1'b1;
        ctl(eeprom_pkg::CMD_START);
        send(devw(straps, 1'b0, 1'b0), 1'b1);
        send(8'h00, 1'b1);
        send(8'h07, 1'b1);
        send(8'h99, 1'b1);
        ctl(eeprom_pkg::CMD_STOP);
        repeat (4) @(posedge clk);
        check(busy, 1'b0);
        check(mem[17'h00007], 8'h3c);
        wp <= 1'b0;
        $display("test write protect done");
        summarize();
    end
endmodule

/* File: verilog/eeprom_target.sv */
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
module eeprom_target #(
    parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    twi_if.device LINK,
    input wire logic DEVICE_SELECT_STRAP_HIGH,
    input wire logic DEVICE_SELECT_STRAP_LOW,
    input wire logic WRITE_PROTECT,
    input wire logic [7:0] MEM_RDATA,
    output logic [16:0] MEM_RADDR,
    output logic [16:0] MEM_WADDR,
    output logic [7:0] MEM_WDATA,
    output logic MEM_WE,
    output logic BUSY,
    output logic STANDBY
);
    typedef enum logic [2:0] {
        IDLE,
        DEVADDR,
        ADDR_HI,
        ADDR_LO,
        WDATA,
        TX,
        WRITING
    } dstate_t;

    typedef struct packed {
        logic [1:0] scl_sy;
        logic [1:0] sda_sy;
        logic [1:0] strap_hi_sy;
        logic [1:0] strap_lo_sy;
        logic [1:0] wp_sy;
        logic scl_q;
        logic sda_q;
        dstate_t st;
        logic [3:0] bits;
        logic [7:0] sh;
        logic mack;
        logic page_address_top_bit;
        logic [7:0] hi;
        logic [16:0] ptr;
        logic [16:0] cnt;
        logic pend;
        logic sda_low;
        logic [8:0] idx;
        logic [31:0] tmr;
        logic [255:0] vld;
        logic [255:0][7:0] pbuf;
        logic we;
        logic [16:0] waddr;
        logic [7:0] wdata;
    } dev_t;

    dev_t r;
    dev_t n;
    logic scl;
    logic sda;
    logic rise;
    logic fall;
    logic start;
    logic stop;

    assign scl = r.scl_sy[1];
    assign sda = r.sda_sy[1];
    assign rise = !r.scl_q && scl;
    assign fall = r.scl_q && !scl;
    assign start = r.scl_q && scl && r.sda_q && !sda;
    assign stop = r.scl_q && scl && !r.sda_q && sda;

    always_comb
    begin
        n = r;
        n.we = 1'b0;
        n.scl_sy = {r.scl_sy[0], LINK.scl};
        n.sda_sy = {r.sda_sy[0], LINK.sda};
        // Strap and protect pins are asynchronous too
        n.strap_hi_sy = {r.strap_hi_sy[0], DEVICE_SELECT_STRAP_HIGH};
        n.strap_lo_sy = {r.strap_lo_sy[0], DEVICE_SELECT_STRAP_LOW};
        n.wp_sy = {r.wp_sy[0], WRITE_PROTECT};
        n.scl_q = scl;
        n.sda_q = sda;
        if (r.st == WRITING)
        begin
            // Bus is deaf for the whole cycle, polls get no ack
            n.tmr = r.tmr + 32'h1;
            if (!r.idx[8])
            begin
                if (r.vld[r.idx[7:0]])
                begin
                    n.we = 1'b1;
                    n.waddr = {r.ptr[16:8], r.idx[7:0]};
                    n.wdata = r.pbuf[r.idx[7:0]];
                end
                n.idx = r.idx + 9'h1;
            end
            if (r.tmr >= 32'(WRITE_CYCLES - 1))
            begin
                n.st = IDLE;
                n.vld = '0;
                n.pend = 1'b0;
            end
        end
        else if (start)
        begin
            // Any start outside the write cycle, even mid byte, restarts framing
            n.st = DEVADDR;
            n.bits = 4'h0;
            n.sda_low = 1'b0;
        end
        else if (stop)
        begin
            n.sda_low = 1'b0;
            n.bits = 4'h0;
            n.st = IDLE;
            if (r.pend)
            begin
                n.st = WRITING;
                n.tmr = 32'h0;
                n.idx = 9'h0;
            end
        end
        else if (r.st != IDLE)
        begin
            if (rise)
            begin
                if (r.bits < 4'h8 && r.st != TX)
                begin
                    n.sh = {r.sh[6:0], sda};
                end
                if (r.bits == 4'h8)
                begin
                    n.mack = !sda;
                end
                n.bits = r.bits + 4'h1;
            end
            if (fall)
            begin
                if (r.bits == 4'h8)
                begin
                    n.sda_low = 1'b1;
                    case (r.st)
                        DEVADDR:
                        begin
                            if (r.sh[7:4] == eeprom_pkg::DEV_TYPE
                                && r.sh[3:2] == {r.strap_hi_sy[1],
                                r.strap_lo_sy[1]})
                            begin
                                n.page_address_top_bit = r.sh[1];
                                n.st = r.sh[0] ? TX : ADDR_HI;
                            end
                            else
                            begin
                                n.sda_low = 1'b0;
                                n.st = IDLE;
                            end
                        end
                        ADDR_HI:
                        begin
                            n.hi = r.sh;
                            n.st = ADDR_LO;
                        end
                        ADDR_LO:
                        begin
                            n.ptr = {r.page_address_top_bit, r.hi, r.sh};
                            n.cnt = n.ptr;
                            n.st = WDATA;
                        end
                        WDATA:
                        begin
                            if (!r.wp_sy[1])
                            begin
                                n.pbuf[r.ptr[7:0]] = r.sh;
                                n.vld[r.ptr[7:0]] = 1'b1;
                                n.pend = 1'b1;
                            end
                            n.ptr[7:0] = r.ptr[7:0] + 8'h1;
                            n.cnt = {r.ptr[16:8], r.ptr[7:0] + 8'h1};
                        end
                        TX:
                        begin
                            // Controller owns the ninth bit of a read byte
                            n.sda_low = 1'b0;
                            n.cnt = r.cnt + 17'h1;
                        end
                        default:
                        begin
                            n.sda_low = 1'b0;
                        end
                    endcase
                end
                else if (r.bits == 4'h9)
                begin
                    n.sda_low = 1'b0;
                    n.bits = 4'h0;
                    if (r.st == TX)
                    begin
                        if (r.mack)
                        begin
                            n.sh = MEM_RDATA;
                            n.sda_low = !MEM_RDATA[7];
                        end
                        else
                        begin
                            n.st = IDLE;
                        end
                    end
                end
                else if (r.st == TX && r.bits != 4'h0)
                begin
                    n.sh = {r.sh[6:0], 1'b0};
                    n.sda_low = !r.sh[6];
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            r <= '0;
            r.scl_sy <= 2'h3;
            r.sda_sy <= 2'h3;
            r.scl_q <= 1'b1;
            r.sda_q <= 1'b1;
            r.st <= IDLE;
        end
        else
        begin
            r <= n;
        end
    end

    assign LINK.sda_dev_o = 1'b0;
    assign LINK.sda_dev_oe = r.sda_low;
    assign MEM_RADDR = r.cnt;
    assign MEM_WADDR = r.waddr;
    assign MEM_WDATA = r.wdata;
    assign MEM_WE = r.we;
    assign BUSY = (r.st == WRITING);
    assign STANDBY = (r.st == IDLE);
endmodule

/* File: verilog/twi_controller.sv */
`timescale 1ns/1ps
module twi_controller (
    input wire logic CLK_SYS,
    input wire logic RST,
    twi_if.controller LINK,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA
);
    typedef enum logic [1:0] {
        C_IDLE,
        C_START,
        C_STOP,
        C_BYTE
    } cstate_t;

    typedef struct packed {
        logic [1:0] sda_sy;
        cstate_t st;
        logic [5:0] div;
        logic [1:0] ph;
        logic [3:0] bits;
        logic [8:0] sh;
        logic [8:0] rx;
        logic [7:0] txd;
        logic [7:0] rxd;
        logic ack;
        logic scl_low;
        logic sda_low;
        logic [7:0] rdo;
    } ctl_t;

    ctl_t r;
    ctl_t n;
    logic tick;

    assign tick = (r.div == 6'(eeprom_pkg::QUARTER_CYCLES - 1));

    always_comb
    begin
        n = r;
        n.sda_sy = {r.sda_sy[0], LINK.sda};
        n.div = tick ? 6'h0 : r.div + 6'h1;
        n.rdo = 8'h00;
        if (RD)
        begin
            case (ADDR)
                eeprom_pkg::TXD_OFS: n.rdo = r.txd;
                eeprom_pkg::RXD_OFS: n.rdo = r.rxd;
                eeprom_pkg::STAT_OFS:
                begin
                    n.rdo[eeprom_pkg::STAT_BUSY_BIT] = (r.st != C_IDLE);
                    n.rdo[eeprom_pkg::STAT_ACK_BIT] = r.ack;
                end
                default: n.rdo = 8'h00;
            endcase
        end
        if (WR && ADDR == eeprom_pkg::TXD_OFS)
        begin
            n.txd = WDATA;
        end
        // Commands while busy are dropped
        if (WR && ADDR == eeprom_pkg::CTRL_OFS && r.st == C_IDLE)
        begin
            n.ph = 2'h0;
            n.bits = 4'h0;
            n.div = 6'h0;
            case (WDATA[eeprom_pkg::CMD_LSB +: 3])
                eeprom_pkg::CMD_START: n.st = C_START;
                eeprom_pkg::CMD_STOP: n.st = C_STOP;
                eeprom_pkg::CMD_WRITE:
                begin
                    n.st = C_BYTE;
                    n.sh = {r.txd, 1'b1};
                end
                eeprom_pkg::CMD_READ:
                begin
                    n.st = C_BYTE;
                    n.sh = {8'hff, !WDATA[eeprom_pkg::ACK_OUT_BIT]};
                end
                default: n.st = C_IDLE;
            endcase
        end
        else if (tick && r.st != C_IDLE)
        begin
            n.ph = r.ph + 2'h1;
            case (r.st)
                C_START:
                begin
                    case (r.ph)
                        2'h0: n.sda_low = 1'b0;
                        2'h1: n.scl_low = 1'b0;
                        2'h2: n.sda_low = 1'b1;
                        default:
                        begin
                            n.scl_low = 1'b1;
                            n.st = C_IDLE;
                        end
                    endcase
                end
                C_STOP:
                begin
                    case (r.ph)
                        2'h0: n.scl_low = 1'b1;
                        2'h1: n.sda_low = 1'b1;
                        2'h2: n.scl_low = 1'b0;
                        default:
                        begin
                            n.sda_low = 1'b0;
                            n.st = C_IDLE;
                        end
                    endcase
                end
                C_BYTE:
                begin
                    case (r.ph)
                        2'h0: n.sda_low = !r.sh[8];
                        2'h1: n.scl_low = 1'b0;
                        2'h2: n.rx = {r.rx[7:0], r.sda_sy[1]};
                        default:
                        begin
                            // Nine clocks per byte; a read with no ack is the recovery clocking
                            n.scl_low = 1'b1;
                            n.sh = {r.sh[7:0], 1'b1};
                            n.bits = r.bits + 4'h1;
                            if (r.bits == 4'h8)
                            begin
                                n.rxd = r.rx[8:1];
                                n.ack = !r.rx[0];
                                n.st = C_IDLE;
                            end
                        end
                    endcase
                end
                default: n.st = C_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            r <= '0;
            r.sda_sy <= 2'h3;
            r.st <= C_IDLE;
        end
        else
        begin
            r <= n;
        end
    end

    assign LINK.scl_ctl_o = 1'b0;
    assign LINK.scl_ctl_oe = r.scl_low;
    assign LINK.sda_ctl_o = 1'b0;
    assign LINK.sda_ctl_oe = r.sda_low;
    assign RDATA = r.rdo;
endmodule
